/* File: gpm_gpio_out_mux.sv */
// output source selector for the general-purpose pins 0 and 1
//
// Overview of operation
// - five-bit field picks pin 0 source; codes 16-17 PLL, osc clock over four; 28-31 low
// - pin 0 source field resets to zero
// - codes 0-2: low, core output, register bit
// - codes 3-5: both, left, right auto-mute
// - code 6: error or changing or missing
// - code 7: serial audio data out
// - codes 8-9: active-low analog mute flags
// - code 10 PLL lock, 11 pump clock
// - code 14: undervoltage above 0.7 supply
// - code 15: undervoltage above 0.3 supply
// - codes 12-13: left, right short flags
// - codes 18-19: left, right impedance sense
// - code 20: undervoltage protect, low when low
// - code 21: high while offset calibration runs
// - codes 22-25: individual clock fault flags
// - code 26: core boot done
// - code 27: active-low pump voltage valid
`include "gpm_params.svh"

module gpm_gpio_out_mux (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_b_i,
  // register port
  input  wire gpm_pkg::gpm_reg_req_s   reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  output logic                         reg_rvalid_o,
  // per-pin direction and software sources
  input  wire logic [1:0]              pin_dir_out_i,
  input  wire logic [1:0]              dsp_pin_out_i,
  input  wire logic [1:0]              reg_pin_out_i,
  // core flags on this clock
  input  wire gpm_pkg::gpm_core_flags_s core_flags_i,
  // analog flags and foreign clocks
  input  wire logic                    cp_clk_i,
  input  wire logic                    pll_clk_i,
  input  wire logic                    osc_clk_i,
  input  wire logic                    short_l_i,
  input  wire logic                    short_r_i,
  input  wire logic                    uv_hi_i,
  input  wire logic                    uv_lo_i,
  input  wire logic                    imp_l_i,
  input  wire logic                    imp_r_i,
  input  wire logic                    undervoltage_protect_i,
  input  wire logic                    cp_valid_n_i,
  // pins, output enable low while driving
  output logic                         pin0_o,
  output logic                         pin0_oe_n_o,
  output logic                         pin1_o,
  output logic                         pin1_oe_n_o,
  // selected fields for the rest of the device
  output gpm_pkg::gpm_sel_t            pin0_source_field_o,
  output gpm_pkg::gpm_sel_t            pin1_source_field_o
);

  // -------------------------------------------
  // declarations
  // -------------------------------------------
  logic [7:0]              pin0_sel_q;
  logic [7:0]              pin1_sel_q;
  logic [7:0]              rdata_q;
  logic                    rvalid_q;
  logic [7:0]              ana_raw;
  logic [7:0]              ana_sync;
  logic [2:0]              clk_raw;
  logic [2:0]              clk_sync;
  logic                    pll_div4;
  logic                    osc_div4;
  gpm_pkg::gpm_ana_flags_s ana;
  gpm_pkg::gpm_sel_t       sel [2];
  logic [1:0]              src;
  logic [1:0]              pin_q;
  logic [1:0]              oe_n_q;

  // -------------------------------------------
  // source map
  // -------------------------------------------
  function automatic logic pick_source(
    input gpm_pkg::gpm_sel_t        code,
    input logic                     dsp_bit,
    input logic                     reg_bit,
    input gpm_pkg::gpm_core_flags_s cf,
    input gpm_pkg::gpm_ana_flags_s  af
  );
    logic v;
    v = 1'b0;
    case (code)
      `GPM_C_OFF:        v = 1'b0;
      `GPM_C_DSP:        v = dsp_bit;
      `GPM_C_REG:        v = reg_bit;
      `GPM_C_AMUTE_LR:   v = cf.amute_l & cf.amute_r;
      `GPM_C_AMUTE_L:    v = cf.amute_l;
      `GPM_C_AMUTE_R:    v = cf.amute_r;
      `GPM_C_CLK_INV:    v = cf.clk_err | cf.clk_chg | cf.clk_miss;
      `GPM_C_SERIAL_AUDIO_OUT:      v = cf.serial_audio_out;
      `GPM_C_ANMUTE_L:   v = cf.anmute_l_n;
      `GPM_C_ANMUTE_R:   v = cf.anmute_r_n;
      `GPM_C_PLL_LOCK:   v = cf.pll_lock;
      `GPM_C_CP_CLK:     v = af.cp_clk;
      `GPM_C_SHORT_L:    v = af.short_l;
      `GPM_C_SHORT_R:    v = af.short_r;
      `GPM_C_UV_HI:      v = af.uv_hi;
      `GPM_C_UV_LO:      v = af.uv_lo;
      `GPM_C_PLL_DIV4:   v = af.pll_div4;
      `GPM_C_OSC_DIV4:   v = af.osc_div4;
      `GPM_C_IMP_L:      v = af.imp_l;
      `GPM_C_IMP_R:      v = af.imp_r;
      `GPM_C_UVP:        v = af.undervoltage_protect;
      `GPM_C_OFS_CAL:    v = cf.ofs_cal;
      `GPM_C_CLK_ERR:    v = cf.clk_err;
      `GPM_C_CLK_CHG:    v = cf.clk_chg;
      `GPM_C_CLK_MISS:   v = cf.clk_miss;
      `GPM_C_CLK_HALT:   v = cf.clk_halt;
      `GPM_C_BOOT_DONE:  v = cf.boot_done;
      `GPM_C_CP_VALID_N: v = af.cp_valid_n;
      default:           v = 1'b0;
    endcase
    return v;
  endfunction : pick_source

  // -------------------------------------------
  // register writes
  // -------------------------------------------
  // upper reserved bits are stored and read back as written
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pin0_sel_q <= `GPM_SEL_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == `GPM_PIN0_SEL_OFS) begin
      pin0_sel_q <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pin1_sel_q <= `GPM_SEL_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == `GPM_PIN1_SEL_OFS) begin
      pin1_sel_q <= reg_req_i.wdata;
    end
  end

  // -------------------------------------------
  // register reads
  // -------------------------------------------
  // an unmapped read answers zero so software never sees stale data
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_q  <= `GPM_RD_UNMAPPED;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        if (reg_req_i.addr == `GPM_PIN0_SEL_OFS) begin
          rdata_q <= pin0_sel_q;
        end else if (reg_req_i.addr == `GPM_PIN1_SEL_OFS) begin
          rdata_q <= pin1_sel_q;
        end else begin
          rdata_q <= `GPM_RD_UNMAPPED;
        end
      end
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // -------------------------------------------
  // input synchronising
  // -------------------------------------------
  // analog comparators and foreign clocks are asynchronous here
  assign ana_raw = {short_l_i, short_r_i, uv_hi_i, uv_lo_i,
                    imp_l_i, imp_r_i, undervoltage_protect_i,
                    cp_valid_n_i};
  assign clk_raw = {cp_clk_i, pll_clk_i, osc_clk_i};

  gpm_sync3 #(
    .W (8)
  ) u_sync_ana (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (ana_raw),
    .sync_o    (ana_sync)
  );

  gpm_sync3 #(
    .W (3)
  ) u_sync_clk (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (clk_raw),
    .sync_o    (clk_sync)
  );

  // -------------------------------------------
  // divided clocks
  // -------------------------------------------
  gpm_div4 u_div_pll (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .lvl_i     (clk_sync[1]),
    .div_o     (pll_div4)
  );

  gpm_div4 u_div_osc (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .lvl_i     (clk_sync[0]),
    .div_o     (osc_div4)
  );

  always_comb begin
    ana.cp_clk     = clk_sync[2];
    ana.short_l    = ana_sync[7];
    ana.short_r    = ana_sync[6];
    ana.uv_hi      = ana_sync[5];
    ana.uv_lo      = ana_sync[4];
    ana.imp_l      = ana_sync[3];
    ana.imp_r      = ana_sync[2];
    ana.undervoltage_protect        = ana_sync[1];
    ana.cp_valid_n = ana_sync[0];
    ana.pll_div4   = pll_div4;
    ana.osc_div4   = osc_div4;
  end

  // -------------------------------------------
  // per-pin selection and drive
  // -------------------------------------------
  assign sel[0] = pin0_sel_q[`GPM_SEL_MSB:`GPM_SEL_LSB];
  assign sel[1] = pin1_sel_q[`GPM_SEL_MSB:`GPM_SEL_LSB];

  // registered pin keeps glitches of the mux off the pad
  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign src[p] = pick_source(sel[p], dsp_pin_out_i[p],
                                reg_pin_out_i[p], core_flags_i, ana);

    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        pin_q[p]  <= 1'b0;
        oe_n_q[p] <= 1'b1;
      end else begin
        pin_q[p]  <= src[p];
        oe_n_q[p] <= ~pin_dir_out_i[p];
      end
    end
  end

  assign pin0_o              = pin_q[0];
  assign pin0_oe_n_o         = oe_n_q[0];
  assign pin1_o              = pin_q[1];
  assign pin1_oe_n_o         = oe_n_q[1];
  assign pin0_source_field_o = sel[0];
  assign pin1_source_field_o = sel[1];

endmodule : gpm_gpio_out_mux

/* File: gpm_params.svh */
// constants for the pin output source selector
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// -------------------------------------------
// register offsets and layout
// -------------------------------------------
`define GPM_PIN1_SEL_OFS 8'h52
`define GPM_PIN0_SEL_OFS 8'h53
`define GPM_SEL_MSB      4
`define GPM_SEL_LSB      0
`define GPM_SEL_RST      8'h00
`define GPM_RD_UNMAPPED  8'h00

// -------------------------------------------
// source codes
// -------------------------------------------
`define GPM_C_OFF        5'h00
`define GPM_C_DSP        5'h01
`define GPM_C_REG        5'h02
`define GPM_C_AMUTE_LR   5'h03
`define GPM_C_AMUTE_L    5'h04
`define GPM_C_AMUTE_R    5'h05
`define GPM_C_CLK_INV    5'h06
`define GPM_C_SERIAL_AUDIO_OUT      5'h07
`define GPM_C_ANMUTE_L   5'h08
`define GPM_C_ANMUTE_R   5'h09
`define GPM_C_PLL_LOCK   5'h0A
`define GPM_C_CP_CLK     5'h0B
`define GPM_C_SHORT_L    5'h0C
`define GPM_C_SHORT_R    5'h0D
`define GPM_C_UV_HI      5'h0E
`define GPM_C_UV_LO      5'h0F
`define GPM_C_PLL_DIV4   5'h10
`define GPM_C_OSC_DIV4   5'h11
`define GPM_C_IMP_L      5'h12
`define GPM_C_IMP_R      5'h13
`define GPM_C_UVP        5'h14
`define GPM_C_OFS_CAL    5'h15
`define GPM_C_CLK_ERR    5'h16
`define GPM_C_CLK_CHG    5'h17
`define GPM_C_CLK_MISS   5'h18
`define GPM_C_CLK_HALT   5'h19
`define GPM_C_BOOT_DONE  5'h1A
`define GPM_C_CP_VALID_N 5'h1B

// -------------------------------------------
// divider
// -------------------------------------------
`define GPM_DIV_BITS     2
`define GPM_DIV_RST      2'h0

`endif

/* File: gpm_pkg.sv */
// types shared by the pin output source selector
package gpm_pkg;

  typedef logic [4:0] gpm_sel_t;

  // register port request, one access per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpm_reg_req_s;

  // core flags already on the system clock
  typedef struct packed {
    logic amute_l;
    logic amute_r;
    logic clk_err;
    logic clk_chg;
    logic clk_miss;
    logic clk_halt;
    logic serial_audio_out;
    logic anmute_l_n;
    logic anmute_r_n;
    logic pll_lock;
    logic ofs_cal;
    logic boot_done;
  } gpm_core_flags_s;

  // analog and foreign-clock levels after synchronising
  typedef struct packed {
    logic cp_clk;
    logic short_l;
    logic short_r;
    logic uv_hi;
    logic uv_lo;
    logic imp_l;
    logic imp_r;
    logic undervoltage_protect;
    logic cp_valid_n;
    logic pll_div4;
    logic osc_div4;
  } gpm_ana_flags_s;

endpackage : gpm_pkg

/* File: gpm_sync3.sv */
// three-stage synchroniser with agreement filter
module gpm_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // only s2 reads s1; the filter looks at s2 and s3
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
        s1_q[b]  <= 1'b0;
        s2_q[b]  <= 1'b0;
        s3_q[b]  <= 1'b0;
        out_q[b] <= 1'b0;
      end else begin
        s1_q[b] <= async_i[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          out_q[b] <= s3_q[b];
        end
      end
    end
  end

  assign sync_o = out_q;

endmodule : gpm_sync3

/* File: gpm_div4.sv */
// divide a synchronised clock level by four
`include "gpm_params.svh"

module gpm_div4 (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // clock level and divided output
  input  wire logic lvl_i,
  output logic      div_o
);

  logic                     prev_q;
  logic [`GPM_DIV_BITS-1:0] cnt_q;

  // limitation: source must be well below half the system clock rate
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b0;
      cnt_q  <= `GPM_DIV_RST;
    end else begin
      prev_q <= lvl_i;
      if (lvl_i && !prev_q) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  assign div_o = cnt_q[`GPM_DIV_BITS-1];

endmodule : gpm_div4

/* File: gpm_pin_watch.sv */
// board-side model of one pin: resolved pad level and edge count
module gpm_pin_watch (
  // clock and counter clear
  input  wire logic clk_sys_i,
  input  wire logic clr_i,
  // pin from the selector
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  // pad level and edges seen while driven
  output logic      pad_o,
  output int        edges_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_q = 1'b0;
  // no pull on the pad, so a released pin shows the inverse of its last level
  assign pad_o = oe_n_i ? ~last_q : pin_i;
  always_ff @(posedge clk_sys_i) begin
    if (!oe_n_i) begin
      last_q <= pin_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (clr_i) begin
      edges_o <= 0;
    end else if (!oe_n_i && pin_i !== last_q) begin
      edges_o <= edges_o + 1;
    end
  end
endmodule : gpm_pin_watch

/* File: gpm_gpio_out_mux_sva.sv */
// port assertions for the pin output source selector
module gpm_gpio_out_mux_sva (
  // clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     rst_b_i,
  // inputs
  input wire gpm_pkg::gpm_reg_req_s    reg_req_i,
  input wire logic [1:0]               pin_dir_out_i,
  input wire logic [1:0]               dsp_pin_out_i,
  input wire gpm_pkg::gpm_core_flags_s core_flags_i,
  // outputs
  input wire logic                     pin0_o,
  input wire logic                     pin0_oe_n_o,
  input wire gpm_pkg::gpm_sel_t        pin0_source_field_o,
  input wire gpm_pkg::gpm_sel_t        pin1_source_field_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // ----------
  // properties
  // ----------
  property p_rst;
    $rose(rst_b_i) |-> pin0_source_field_o == 5'h00 && pin1_source_field_o == 5'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("field not cleared by reset");
  property p_oe;
    pin_dir_out_i[0] |=> !pin0_oe_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven as output");
  property p_wr0;
    reg_req_i.wr && reg_req_i.addr == 8'h53 |-> ##1
      pin0_source_field_o == $past(reg_req_i.wdata[4:0]);
  endproperty
  a_wr0: assert property (p_wr0) else $error("pin 0 field not written");
  property p_wr1;
    reg_req_i.wr && reg_req_i.addr == 8'h52 |=>
      pin1_source_field_o == $past(reg_req_i.wdata[4:0]);
  endproperty
  a_wr1: assert property (p_wr1) else $error("pin 1 field not written");
  property p_high;
    pin0_source_field_o >= 5'h1C |=> !pin0_o;
  endproperty
  a_high: assert property (p_high) else $error("unlisted code not low");
  property p_dsp;
    pin0_source_field_o == 5'h01 |=> pin0_o == $past(dsp_pin_out_i[0]);
  endproperty
  a_dsp: assert property (p_dsp) else $error("core output not routed");
  property p_and;
    pin0_source_field_o == 5'h03 |=>
      pin0_o == $past(core_flags_i.amute_l & core_flags_i.amute_r);
  endproperty
  a_and: assert property (p_and) else $error("joint mute flag wrong");
  property p_inv;
    pin0_source_field_o == 5'h06 |=>
      pin0_o == $past(core_flags_i.clk_err | core_flags_i.clk_chg | core_flags_i.clk_miss);
  endproperty
  a_inv: assert property (p_inv) else $error("clock invalid flag wrong");
endmodule : gpm_gpio_out_mux_sva

/* File: gpm_gpio_out_mux_bench.sv */
// self-checking bench for the pin output source selector
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module gpm_gpio_out_mux_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_b_i = 1'b0;
  gpm_pkg::gpm_reg_req_s    req = '0;
  gpm_pkg::gpm_core_flags_s core = '0;
  logic [7:0]               ana = 8'h00;
  logic [7:0]               rdata;
  logic [1:0]               dir = 2'h0;
  logic [1:0]               dsp = 2'h0;
  logic [1:0]               regb = 2'h0;
  logic                     cp_clk = 1'b0, pll_clk = 1'b0, osc_clk = 1'b0, clr = 1'b1;
  logic                     rvalid, pin0, pin1, oe0_n, oe1_n, pad0, pad1;
  gpm_pkg::gpm_sel_t        fld0, fld1;
  int                       err_total = 0, n_checks = 0, e0, e1;
  logic [24:0]              pats [4] = '{25'h0000000, 25'h1FFFFFF, 25'h0AAAAAA, 25'h1555555};
  always #12.5 clk_sys_i = ~clk_sys_i;
  gpm_gpio_out_mux dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .pin_dir_out_i(dir), .dsp_pin_out_i(dsp),
    .reg_pin_out_i(regb), .core_flags_i(core), .cp_clk_i(cp_clk), .pll_clk_i(pll_clk),
    .osc_clk_i(osc_clk), .short_l_i(ana[7]), .short_r_i(ana[6]), .uv_hi_i(ana[5]),
    .uv_lo_i(ana[4]), .imp_l_i(ana[3]), .imp_r_i(ana[2]), .undervoltage_protect_i(ana[1]),
    .cp_valid_n_i(ana[0]), .pin0_o(pin0), .pin0_oe_n_o(oe0_n), .pin1_o(pin1),
    .pin1_oe_n_o(oe1_n), .pin0_source_field_o(fld0), .pin1_source_field_o(fld1));
  gpm_pin_watch w0_u (.clk_sys_i(clk_sys_i), .clr_i(clr), .pin_i(pin0), .oe_n_i(oe0_n),
    .pad_o(pad0), .edges_o(e0));
  gpm_pin_watch w1_u (.clk_sys_i(clk_sys_i), .clr_i(clr), .pin_i(pin1), .oe_n_i(oe1_n),
    .pad_o(pad1), .edges_o(e1));
  // -----------
  // bus and map
  // -----------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #2;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i) #2;
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #2;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i) #2;
    req = '0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, d)
  endtask : rd
  function automatic logic expv(input logic [4:0] c, input int p);
    case (c)
      5'h01: return dsp[p];
      5'h02: return regb[p];
      5'h03: return core.amute_l & core.amute_r;
      5'h04: return core.amute_l;
      5'h05: return core.amute_r;
      5'h06: return core.clk_err | core.clk_chg | core.clk_miss;
      5'h07: return core.serial_audio_out;
      5'h08: return core.anmute_l_n;
      5'h09: return core.anmute_r_n;
      5'h0A: return core.pll_lock;
      5'h0B: return cp_clk;
      5'h0C: return ana[7];
      5'h0D: return ana[6];
      5'h0E: return ana[5];
      5'h0F: return ana[4];
      5'h12: return ana[3];
      5'h13: return ana[2];
      5'h14: return ana[1];
      5'h15: return core.ofs_cal;
      5'h16: return core.clk_err;
      5'h17: return core.clk_chg;
      5'h18: return core.clk_miss;
      5'h19: return core.clk_halt;
      5'h1A: return core.boot_done;
      5'h1B: return ana[0];
      default: return 1'b0;
    endcase
  endfunction : expv
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // --------
  // sequence
  // --------
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #2 rst_b_i = 1'b1;
    rd(8'h53, 8'h00);
    rd(8'h52, 8'h00);
    wr(8'h53, 8'hE7);
    wr(8'h54, 8'h5A);
    rd(8'h53, 8'hE7);
    rd(8'h54, 8'h00);
    `CHK(fld0, 5'h07)
    `CHK(oe0_n, 1'b1)
    `CHK(oe1_n, 1'b1)
    dir = 2'h3;
    repeat (2) @(posedge clk_sys_i);
    #2;
    `CHK(oe0_n, 1'b0)
    `CHK(pad0, 1'b0)
    `CHK(oe1_n, 1'b0)
    `CHK(pad1, 1'b0)
    for (int k = 0; k < 4; k++) begin
      {core, ana, cp_clk, dsp, regb} = pats[k];
      for (int c = 0; c < 32; c++) begin
        if (c == 16 || c == 17) continue;
        wr(8'h53, 8'(c));
        wr(8'h52, 8'(c));
        repeat (6) @(posedge clk_sys_i);
        #2;
        `CHK(pin0, expv(5'(c), 0))
        `CHK(pin1, expv(5'(c), 1))
      end
    end
    // slow clocks only: the divider counts resampled edges
    wr(8'h53, 8'h10);
    wr(8'h52, 8'h11);
    repeat (3) @(posedge clk_sys_i);
    #2 clr = 1'b0;
    repeat (32) begin
      repeat (8) @(posedge clk_sys_i);
      #2;
      pll_clk = ~pll_clk;
      osc_clk = ~osc_clk;
    end
    repeat (8) @(posedge clk_sys_i);
    #2;
    `CHK(e0, 8)
    `CHK(e1, 8)
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #2 rst_b_i = 1'b1;
    `CHK(fld0, 5'h00)
    `CHK(fld1, 5'h00)
    rd(8'h52, 8'h00);
    report_and_stop();
  end
endmodule : gpm_gpio_out_mux_bench
bind gpm_gpio_out_mux gpm_gpio_out_mux_sva chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .reg_req_i(reg_req_i), .pin_dir_out_i(pin_dir_out_i), .dsp_pin_out_i(dsp_pin_out_i),
  .core_flags_i(core_flags_i), .pin0_o(pin0_o), .pin0_oe_n_o(pin0_oe_n_o),
  .pin0_source_field_o(pin0_source_field_o), .pin1_source_field_o(pin1_source_field_o));
